// ==== bcc_pkg.sv ====
// Purpose: Shared constants and BCD helpers for the calendar clock word area
// Assumes: 32-bit AXI4-Lite data, 16-bit calendar words in the low half
// Notes: Word indexes are kept; byte address is four times the index
package bcc_pkg;
	localparam int ADDR_W = 8;
	// Word indexes of the auxiliary word area
	localparam logic [5:0] IDX_SEC_MIN = 6'h12;
	localparam logic [5:0] IDX_HOUR_DAY = 6'h13;
	localparam logic [5:0] IDX_MON_YEAR = 6'h14;
	localparam logic [5:0] IDX_WDAY_CTL = 6'h15;
	// Control bit positions in the weekday word
	localparam int BIT_ROUND = 13;
	localparam int BIT_STOP = 14;
	localparam int BIT_SET = 15;
	// Values after reset: 2000-01-01 00:00:00, Saturday
	localparam logic [7:0] RST_SEC = 8'h00;
	localparam logic [7:0] RST_MIN = 8'h00;
	localparam logic [7:0] RST_HOUR = 8'h00;
	localparam logic [7:0] RST_DAY = 8'h01;
	localparam logic [7:0] RST_MON = 8'h01;
	localparam logic [7:0] RST_YEAR = 8'h00;
	localparam logic [7:0] RST_WDAY = 8'h06;
	// Field limits
	localparam logic [7:0] MAX_SEC = 8'h59;
	localparam logic [7:0] MAX_MIN = 8'h59;
	localparam logic [7:0] MAX_HOUR = 8'h23;
	localparam logic [7:0] MAX_MON = 8'h12;
	localparam logic [7:0] MAX_YEAR = 8'h99;
	localparam logic [7:0] MAX_WDAY = 8'h06;
	localparam logic [7:0] FIRST_DAY = 8'h01;
	localparam logic [7:0] HALF_MIN = 8'h30;
	// Timing
	localparam int CLK_NS = 100;
	localparam int SEC_NS = 1000000000;
	localparam int SCAN_NS = 1000000;
	localparam int SEC_CYC = SEC_NS / CLK_NS;
	localparam int SCAN_CYC = SCAN_NS / CLK_NS;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			return {v[7:4] + 4'h1, 4'h0};
		end
		return v + 8'h01;
	endfunction

	function automatic logic [7:0] last_day(input logic [7:0] mon, input logic [7:0] year);
		logic leap;
		leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
			: (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
		case (mon)
			8'h02: last_day = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
			default: last_day = 8'h31;
		endcase
	endfunction
endpackage

// ==== bcc_calendar_step.sv ====
// Purpose: Next calendar state after one second or one rounded minute
// Assumes: Fields hold valid BCD within range
// Notes: Purely combinational; the caller decides when to take it
`timescale 1ns/1ps
`default_nettype none
module bcc_calendar_step (
	input wire logic step_min,
	input wire logic [7:0] sec,
	input wire logic [7:0] min,
	input wire logic [7:0] hour,
	input wire logic [7:0] day,
	input wire logic [7:0] mon,
	input wire logic [7:0] year,
	input wire logic [7:0] wday,
	output logic [7:0] next_sec,
	output logic [7:0] next_min,
	output logic [7:0] next_hour,
	output logic [7:0] next_day,
	output logic [7:0] next_mon,
	output logic [7:0] next_year,
	output logic [7:0] next_wday
);
	logic c_min, c_hour, c_day, c_mon, c_year;
	always_comb begin
		c_min = step_min || sec == bcc_pkg::MAX_SEC;
		next_sec = c_min ? 8'h00 : bcc_pkg::bcd_inc(sec); // see (RULE2)
		c_hour = c_min && min == bcc_pkg::MAX_MIN;
		next_min = c_hour ? 8'h00 : (c_min ? bcc_pkg::bcd_inc(min) : min);
		c_day = c_hour && hour == bcc_pkg::MAX_HOUR;
		next_hour = c_day ? 8'h00 : (c_hour ? bcc_pkg::bcd_inc(hour) : hour); // see (RULE3)
		c_mon = c_day && day == bcc_pkg::last_day(mon, year);
		next_day = c_mon ? bcc_pkg::FIRST_DAY : (c_day ? bcc_pkg::bcd_inc(day) : day); // see (RULE4)
		c_year = c_mon && mon == bcc_pkg::MAX_MON;
		next_mon = c_year ? 8'h01 : (c_mon ? bcc_pkg::bcd_inc(mon) : mon); // see (RULE5)
		next_year = (c_year && year == bcc_pkg::MAX_YEAR) ? 8'h00 : (c_year ? bcc_pkg::bcd_inc(year) : year);
		next_wday = c_day ? ((wday == bcc_pkg::MAX_WDAY) ? 8'h00 : bcc_pkg::bcd_inc(wday)) : wday; // see (RULE6)
	end
endmodule
`default_nettype wire

// ==== bcc_calendar_clock.sv ====
// Purpose: BCD calendar clock in four auxiliary words, AXI4-Lite slave
// Assumes: Single 10 MHz clock, synchronous active-low reset
// Notes: Fields change only on a scan tick; bus writes land at once
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RULE1) With stop clear, keep the calendar running and show it in BCD words.
// (RULE2) Word one: seconds low byte, minutes high byte, each 00 to 59.
// (RULE3) Word two low byte: hours 00 to 23, 24-hour count.
// (RULE4) Word two high byte: day 01 to 31, honouring month length and leap years.
// (RULE5) Word three: month 1 to 12 low byte, two-digit year high byte.
// (RULE6) Word four low byte: weekday 00 Sunday through 06 Saturday, daily step.
// (RULE7) Round bit: seconds to 00; at 30 or more also add one minute.
// (RULE8) Advance only while stop is clear; halt while stop is set.
// (RULE9) Writer sets stop, writes valid BCD fields, then sets load.
// (RULE10) Writer keeps stop set when writing the weekday byte.
// (RULE11) Load bit resumes counting and clears both load and stop.
// (RULE12) Words and control bits refresh once per scan cycle.
// (RULE13) Round bit clears itself after one adjustment.
module bcc_calendar_clock #(
	parameter int SEC_CYC = bcc_pkg::SEC_CYC,
	parameter int SCAN_CYC = bcc_pkg::SCAN_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [bcc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [bcc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	logic [7:0] sec, min, hour, day, mon, year, wday;
	logic ctl_round, ctl_stop, ctl_set;
	logic [7:0] st_sec, st_min, st_hour, st_day, st_mon, st_year, st_wday;
	logic [31:0] scan_cnt, sec_cnt;
	logic scan_tick, sec_pend;
	logic aw_hold, w_hold;
	logic [bcc_pkg::ADDR_W-1:0] aw_addr;
	logic [15:0] w_data;
	logic [1:0] w_strb;
	logic wr_fire;
	logic [2:0] wr_sel, rd_sel;
	logic [15:0] rd_word;

	// Word select; 3'h4 marks an unmapped or unaligned address
	function automatic logic [2:0] word_sel(input logic [bcc_pkg::ADDR_W-1:0] a);
		if (a[1:0] != 2'b00) begin
			return 3'h4;
		end
		case (a[bcc_pkg::ADDR_W-1:2])
			bcc_pkg::IDX_SEC_MIN: return 3'h0;
			bcc_pkg::IDX_HOUR_DAY: return 3'h1;
			bcc_pkg::IDX_MON_YEAR: return 3'h2;
			bcc_pkg::IDX_WDAY_CTL: return 3'h3;
			default: return 3'h4;
		endcase
	endfunction

	// Scan cycle divider
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scan_cnt <= 32'h0;
			scan_tick <= 1'b0;
		end else if (scan_cnt == 32'(SCAN_CYC - 1)) begin
			scan_cnt <= 32'h0;
			scan_tick <= 1'b1;
		end else begin
			scan_cnt <= scan_cnt + 32'h1;
			scan_tick <= 1'b0;
		end
	end

	// One-second timebase, held at zero while stopped so a restart gets a full second
	always_ff @(posedge aclk) begin
		if (!aresetn || ctl_stop) begin
			sec_cnt <= 32'h0;
		end else if (sec_cnt == 32'(SEC_CYC - 1)) begin
			sec_cnt <= 32'h0;
		end else begin
			sec_cnt <= sec_cnt + 32'h1;
		end
	end

	// Pending second waits for the next scan; a new second beats the consume; a stop drops it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sec_pend <= 1'b0;
		end else if (!ctl_stop && sec_cnt == 32'(SEC_CYC - 1)) begin
			sec_pend <= 1'b1; // see (RULE8)
		end else if (scan_tick || ctl_stop) begin
			sec_pend <= 1'b0; // see (RULE12)
		end
	end

	bcc_calendar_step u_step (
		.step_min(ctl_round),
		.sec(sec),
		.min(min),
		.hour(hour),
		.day(day),
		.mon(mon),
		.year(year),
		.wday(wday),
		.next_sec(st_sec),
		.next_min(st_min),
		.next_hour(st_hour),
		.next_day(st_day),
		.next_mon(st_mon),
		.next_year(st_year),
		.next_wday(st_wday)
	);

	assign wr_fire = aw_hold && w_hold && !bvalid;
	assign wr_sel = word_sel(aw_addr);

	// Calendar state; bus write comes last so a software set beats a hardware clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sec <= bcc_pkg::RST_SEC;
			min <= bcc_pkg::RST_MIN;
			hour <= bcc_pkg::RST_HOUR;
			day <= bcc_pkg::RST_DAY;
			mon <= bcc_pkg::RST_MON;
			year <= bcc_pkg::RST_YEAR;
			wday <= bcc_pkg::RST_WDAY;
			ctl_round <= 1'b0;
			ctl_stop <= 1'b0;
			ctl_set <= 1'b0;
		end else begin
			if (scan_tick) begin // see (RULE12)
				if (ctl_round) begin
					ctl_round <= 1'b0; // see (RULE13)
					sec <= 8'h00; // see (RULE7)
					if (sec >= bcc_pkg::HALF_MIN) begin
						min <= st_min; // see (RULE7)
						hour <= st_hour;
						day <= st_day;
						mon <= st_mon;
						year <= st_year;
						wday <= st_wday;
					end
				end else if (ctl_set) begin
					ctl_set <= 1'b0; // see (RULE11)
					ctl_stop <= 1'b0; // see (RULE11)
				end else if (sec_pend && !ctl_stop) begin // see (RULE1)
					sec <= st_sec;
					min <= st_min;
					hour <= st_hour;
					day <= st_day;
					mon <= st_mon;
					year <= st_year;
					wday <= st_wday;
				end
			end
			// Writer is trusted to stop first and keep stop set (RULE9/RULE10 on its side)
			if (wr_fire) begin // see (RULE9)
				case (wr_sel)
					3'h0: begin
						if (w_strb[0]) sec <= w_data[7:0];
						if (w_strb[1]) min <= w_data[15:8];
					end
					3'h1: begin
						if (w_strb[0]) hour <= w_data[7:0];
						if (w_strb[1]) day <= w_data[15:8];
					end
					3'h2: begin
						if (w_strb[0]) mon <= w_data[7:0];
						if (w_strb[1]) year <= w_data[15:8];
					end
					3'h3: begin
						if (w_strb[0]) wday <= w_data[7:0];
						if (w_strb[1]) begin
							ctl_round <= w_data[bcc_pkg::BIT_ROUND];
							ctl_stop <= w_data[bcc_pkg::BIT_STOP]; // see (RULE10)
							ctl_set <= w_data[bcc_pkg::BIT_SET];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Write address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			aw_hold <= 1'b0;
			aw_addr <= '0;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_hold <= 1'b1;
			aw_addr <= awaddr;
		end else begin
			if (wr_fire) aw_hold <= 1'b0;
			awready <= !aw_hold && !bvalid;
		end
	end

	// Write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b0;
			w_hold <= 1'b0;
			w_data <= 16'h0;
			w_strb <= 2'b00;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
			w_hold <= 1'b1;
			w_data <= wdata[15:0];
			w_strb <= wstrb[1:0];
		end else begin
			if (wr_fire) w_hold <= 1'b0;
			wready <= !w_hold && !bvalid;
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= bcc_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= (wr_sel == 3'h4) ? bcc_pkg::RESP_SLVERR : bcc_pkg::RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	assign rd_sel = word_sel(araddr);

	always_comb begin
		case (rd_sel)
			3'h0: rd_word = {min, sec}; // see (RULE2)
			3'h1: rd_word = {day, hour}; // see (RULE3)
			3'h2: rd_word = {year, mon}; // see (RULE5)
			3'h3: rd_word = {ctl_set, ctl_stop, ctl_round, 5'h00, wday}; // see (RULE6)
			default: rd_word = 16'h0;
		endcase
	end

	// Read channel; upper half always reads zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= bcc_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {16'h0, rd_word};
			rresp <= (rd_sel == 3'h4) ? bcc_pkg::RESP_SLVERR : bcc_pkg::RESP_OKAY;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end else begin
			arready <= !rvalid;
		end
	end

	// Checks
	logic adv;
	assign adv = scan_tick && sec_pend && !ctl_stop && !ctl_set && !ctl_round && !wr_fire;

	property p_run;
		@(posedge aclk) disable iff (!aresetn)
		adv |=> sec != $past(sec);
	endproperty
	a_run: assert property (p_run) else $error("running clock did not advance seconds"); // see (RULE1)

	property p_sec_wrap;
		@(posedge aclk) disable iff (!aresetn)
		(adv && sec == 8'h59) |=> (sec == 8'h00 && min != $past(min));
	endproperty
	a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap into minutes"); // see (RULE2)

	property p_hour_wrap;
		@(posedge aclk) disable iff (!aresetn)
		(adv && sec == 8'h59 && min == 8'h59 && hour == 8'h23) |=> (hour == 8'h00 && min == 8'h00);
	endproperty
	a_hour_wrap: assert property (p_hour_wrap) else $error("hours did not wrap at 23"); // see (RULE3)

	property p_leap_day;
		@(posedge aclk) disable iff (!aresetn)
		(adv && sec == 8'h59 && min == 8'h59 && hour == 8'h23 && day == 8'h28 && mon == 8'h02)
			|=> ((((int'(year[7:4]) * 10 + int'(year[3:0])) % 4) == 0) ? (day == 8'h29 && mon == 8'h02)
			: (day == 8'h01 && mon == 8'h03));
	endproperty
	a_leap_day: assert property (p_leap_day) else $error("february end handled wrongly"); // see (RULE4)

	property p_year_wrap;
		@(posedge aclk) disable iff (!aresetn)
		(adv && sec == 8'h59 && min == 8'h59 && hour == 8'h23 && day == 8'h31 && mon == 8'h12)
			|=> (mon == 8'h01 && day == 8'h01 && year != $past(year));
	endproperty
	a_year_wrap: assert property (p_year_wrap) else $error("new year did not roll month and year"); // see (RULE5)

	property p_wday;
		@(posedge aclk) disable iff (!aresetn)
		(adv && sec == 8'h59 && min == 8'h59 && hour == 8'h23 && wday == 8'h06) |=> wday == 8'h00;
	endproperty
	a_wday: assert property (p_wday) else $error("weekday did not wrap after Saturday"); // see (RULE6)

	property p_round_low;
		@(posedge aclk) disable iff (!aresetn)
		(scan_tick && ctl_round && !wr_fire && sec < 8'h30) |=> (sec == 8'h00 && $stable(min));
	endproperty
	a_round_low: assert property (p_round_low) else $error("rounding below 30 changed minutes"); // see (RULE7)

	property p_round_high;
		@(posedge aclk) disable iff (!aresetn)
		(scan_tick && ctl_round && !wr_fire && sec >= 8'h30) |=> (sec == 8'h00 && min != $past(min));
	endproperty
	a_round_high: assert property (p_round_high) else $error("rounding above 30 missed the minute"); // see (RULE7)

	property p_stop;
		@(posedge aclk) disable iff (!aresetn)
		(ctl_stop && !ctl_set && !ctl_round && !wr_fire) |=> ($stable(sec) && $stable(day) && !sec_pend);
	endproperty
	a_stop: assert property (p_stop) else $error("stopped clock changed"); // see (RULE8)

	property p_load;
		@(posedge aclk) disable iff (!aresetn)
		(scan_tick && ctl_set && !ctl_round && !wr_fire) |=> (!ctl_set && !ctl_stop && $stable(sec));
	endproperty
	a_load: assert property (p_load) else $error("load did not clear load and stop"); // see (RULE11)

	property p_scan_only;
		@(posedge aclk) disable iff (!aresetn)
		(!scan_tick && !wr_fire) |=> ($stable(sec) && $stable(min) && $stable(ctl_round) && $stable(ctl_set));
	endproperty
	a_scan_only: assert property (p_scan_only) else $error("calendar changed between scans"); // see (RULE12)

	property p_round_once;
		@(posedge aclk) disable iff (!aresetn)
		(scan_tick && ctl_round && !wr_fire) |=> !ctl_round [*2];
	endproperty
	a_round_once: assert property (p_round_once) else $error("round bit not cleared"); // see (RULE13)

	c_load: cover property (@(posedge aclk) disable iff (!aresetn) scan_tick && ctl_set);
	c_round: cover property (@(posedge aclk) disable iff (!aresetn) scan_tick && ctl_round && sec >= 8'h30);
	c_minute: cover property (@(posedge aclk) disable iff (!aresetn) adv && sec == 8'h59);
	c_unmapped: cover property (@(posedge aclk) disable iff (!aresetn) bvalid && bresp == bcc_pkg::RESP_SLVERR);
endmodule
`default_nettype wire

// ==== bcc_calendar_clock_test.sv ====
// Purpose: Self-checking bench for the calendar clock word area over AXI4-Lite
// Assumes: Short second and scan counts so rollovers show within a few hundred cycles
// Notes: Polls words instead of counting cycles; a read takes several cycles
`timescale 1ns/1ps
`default_nettype none
module bcc_calendar_clock_test;
	localparam int SEC = 20;
	localparam int SCAN = 5;
	logic aclk;
	logic aresetn;
	logic [7:0] awaddr;
	logic awvalid;
	logic awready;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic wvalid;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready;
	logic [7:0] araddr;
	logic arvalid;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready;
	int n_errors;
	int n_checks;
	logic [31:0] rd;
	logic [1:0] rs;
	// Rollover table: start words, then expected words one second later
	logic [15:0] c_sm [4] = '{16'h5959, 16'h5959, 16'h5959, 16'h5959};
	logic [15:0] c_hd [4] = '{16'h2823, 16'h2823, 16'h3123, 16'h3023};
	logic [15:0] c_my [4] = '{16'h0002, 16'h0102, 16'h9912, 16'h0504};
	logic [15:0] c_wd [4] = '{16'h0003, 16'h0003, 16'h0006, 16'h0001};
	logic [15:0] e_hd [4] = '{16'h2900, 16'h0100, 16'h0100, 16'h0100};
	logic [15:0] e_my [4] = '{16'h0002, 16'h0103, 16'h0001, 16'h0505};
	logic [15:0] e_wd [4] = '{16'h0004, 16'h0004, 16'h0000, 16'h0002};

	bcc_calendar_clock #(.SEC_CYC(SEC), .SCAN_CYC(SCAN)) u_bcc_calendar_clock (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready)
	);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic close_out();
		if (n_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Both channels offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {16'h0000, d};
		wstrb <= 4'h3;
		wvalid <= 1'b1;
		bready <= 1'b1;
		r = 2'bxx;
		while (n < 200) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				n = 1000;
			end
		end
	endtask

	task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		d = 'x;
		r = 2'bxx;
		while (n < 200) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				n = 1000;
			end
		end
	endtask

	// Reads until the word differs from old, bounded
	task automatic poll(input logic [7:0] a, input logic [31:0] old, output logic [31:0] d);
		int n;
		logic [1:0] r;
		n = 0;
		d = old;
		while (d === old && n < 100) begin
			rdw(a, d, r);
			n++;
		end
	endtask

	task automatic wr_ok(input logic [7:0] a, input logic [15:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk({30'h0, r}, {30'h0, bcc_pkg::RESP_OKAY});
	endtask

	initial begin
		int i;
		n_errors = 0;
		n_checks = 0;
		aresetn = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		// Values after reset; the clock may already have ticked a second
		rdw(8'h4c, rd, rs);
		chk(rd, 32'h0000_0100);
		rdw(8'h50, rd, rs);
		chk(rd, 32'h0000_0001);
		rdw(8'h54, rd, rs);
		chk(rd, 32'h0000_0006);
		rdw(8'h40, rd, rs);
		chk({rd[15:0], 14'h0, rs}, {16'h0, 14'h0, bcc_pkg::RESP_SLVERR});
		wr(8'h40, 16'h1234, rs);
		chk({30'h0, rs}, {30'h0, bcc_pkg::RESP_SLVERR});
		// Rounding while stopped: below half, then at half with carry into the hour
		wr_ok(8'h54, 16'h4003);
		for (i = 0; i < 2; i++) begin
			wr_ok(8'h48, i == 0 ? 16'h1029 : 16'h5930);
			wr_ok(8'h4c, 16'h1505);
			wr_ok(8'h54, 16'h6003);
			poll(8'h54, 32'h6003, rd);
			chk(rd, 32'h0000_4003);
			rdw(8'h48, rd, rs);
			chk(rd, i == 0 ? 32'h1000 : 32'h0000);
			rdw(8'h4c, rd, rs);
			chk(rd, i == 0 ? 32'h1505 : 32'h1506);
		end
		// Loads across day, month, year and leap boundaries
		for (i = 0; i < 4; i++) begin
			wr_ok(8'h54, 16'h4000 | c_wd[i]);
			wr_ok(8'h48, c_sm[i]);
			wr_ok(8'h4c, c_hd[i]);
			wr_ok(8'h50, c_my[i]);
			repeat (3 * SEC) @(posedge aclk);
			rdw(8'h48, rd, rs);
			chk(rd, {16'h0, c_sm[i]});
			wr_ok(8'h54, 16'hc000 | c_wd[i]);
			poll(8'h54, {16'h0, 16'hc000 | c_wd[i]}, rd);
			chk(rd, {16'h0, c_wd[i]});
			poll(8'h48, {16'h0, c_sm[i]}, rd);
			chk(rd, 32'h0000_0000);
			rdw(8'h4c, rd, rs);
			chk(rd, {16'h0, e_hd[i]});
			chk({30'h0, rs}, {30'h0, bcc_pkg::RESP_OKAY});
			rdw(8'h50, rd, rs);
			chk(rd, {16'h0, e_my[i]});
			rdw(8'h54, rd, rs);
			chk(rd, {16'h0, e_wd[i]});
		end
		// Running clock keeps counting seconds
		poll(8'h48, 32'h0, rd);
		chk(rd, 32'h0000_0001);
		close_out();
	end

	// Whole run needs several hundred cycles
	initial begin
		#(20000 * 100);
		n_errors++;
		close_out();
	end
endmodule
`default_nettype wire
